// [pms_consts.svh]
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH

// observable sample width and count
`define PMS_W 16
`define PMS_N 4
`define PMS_IW 2
// running average accumulators
`define PMS_SUM_W 32
`define PMS_CNT_W 16
// response word counter: four words per observable
`define PMS_WC_W 4
`define PMS_WC_LAST 4'hf
// field order inside one observable's group of words
`define PMS_FLD_MIN 2'h0
`define PMS_FLD_AVG 2'h1
`define PMS_FLD_MAX 2'h2
`define PMS_FLD_CUR 2'h3
// command codes
`define PMS_CMD_FEAT 16'h0042
`define PMS_CMD_PMFEAT 16'h0201
`define PMS_CMD_MODE 16'h0200
`define PMS_CMD_READ 16'h0220
`define PMS_CMD_CLEAR 16'h0221
// feature answers
`define PMS_FEAT_GEN 16'h0001
`define PMS_FEAT_PM 16'h040f
`define PMS_ZERO_WORD 16'h0000

`endif

// [pms_pkg.sv]
`include "pms_consts.svh"

package pms_pkg;

  typedef enum logic {
    PMS_MODE_INDEP,
    PMS_MODE_LINKED
  } pms_mode_e;

  typedef enum logic {
    PMS_IDLE,
    PMS_STREAM
  } pms_state_e;

  typedef struct packed {
    logic seen;
    logic [`PMS_W-1:0] min;
    logic [`PMS_W-1:0] max;
    logic [`PMS_SUM_W-1:0] sum;
    logic [`PMS_CNT_W-1:0] cnt;
  } pms_stat_s;

  typedef struct packed {
    pms_state_e state;
    pms_mode_e mode;
    logic [`PMS_WC_W-1:0] word;
    pms_stat_s [1:0][`PMS_N-1:0] set;
    logic [`PMS_N-1:0][`PMS_W-1:0] cur;
    logic rsp_valid;
    logic rsp_last;
    logic rsp_err;
    logic [`PMS_W-1:0] rsp_data;
    logic [`PMS_W-1:0] diag_min;
    logic [`PMS_W-1:0] diag_avg;
    logic [`PMS_W-1:0] diag_max;
    logic [`PMS_W-1:0] diag_cur;
  } pms_reg_s;

endpackage

// [pms_collector.sv]
`timescale 1ns/1ns
`include "pms_consts.svh"
module pms_collector (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // monitored observables, one sample word each
  input wire logic [`PMS_N-1:0] sample_valid,
  input wire logic [`PMS_N*`PMS_W-1:0] sample_data,
  // module restart event, including run-image restarts
  input wire logic module_restart,
  // command_message_channel request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [15:0] cmd_code,
  input wire logic [15:0] cmd_arg,
  // command_message_channel answer
  output logic rsp_valid,
  output logic [`PMS_W-1:0] rsp_data,
  output logic rsp_last,
  output logic rsp_err,
  // flag_based_diag_pages statistics view
  input wire logic [`PMS_IW-1:0] diag_obs,
  input wire logic diag_clear,
  output logic [`PMS_W-1:0] diag_min,
  output logic [`PMS_W-1:0] diag_avg,
  output logic [`PMS_W-1:0] diag_max,
  output logic [`PMS_W-1:0] diag_cur,
  // status
  output logic linked_mode
);

  pms_pkg::pms_reg_s r_reg;
  pms_pkg::pms_reg_s r_next;

  // halving both terms on saturation keeps the average honest instead of freezing it
  function automatic pms_pkg::pms_stat_s stat_update(input pms_pkg::pms_stat_s s,
                                                     input logic [`PMS_W-1:0] d);
    pms_pkg::pms_stat_s o;
    o = s;
    if (&s.cnt) begin
      o.sum = s.sum >> 1;
      o.cnt = s.cnt >> 1;
    end
    o.sum = o.sum + {{(`PMS_SUM_W-`PMS_W){1'b0}}, d};
    o.cnt = o.cnt + {{(`PMS_CNT_W-1){1'b0}}, 1'b1};
    if (!s.seen) begin
      o.min = d;
      o.max = d;
    end else begin
      if (d < s.min) begin
        o.min = d;
      end
      if (d > s.max) begin
        o.max = d;
      end
    end
    o.seen = 1'b1;
    return o;
  endfunction

  function automatic logic [`PMS_W-1:0] stat_avg(input pms_pkg::pms_stat_s s);
    logic [`PMS_SUM_W-1:0] q;
    q = '0;
    if (s.cnt != '0) begin
      q = s.sum / {{(`PMS_SUM_W-`PMS_CNT_W){1'b0}}, s.cnt};
    end
    return q[`PMS_W-1:0];
  endfunction

  function automatic pms_pkg::pms_stat_s stat_clear(input pms_pkg::pms_stat_s s);
    pms_pkg::pms_stat_s o;
    o = s;
    o.seen = 1'b0;
    o.sum = '0;
    o.cnt = '0;
    o.min = '0;
    o.max = '0;
    return o;
  endfunction

  function automatic logic [`PMS_W-1:0] stat_field(input pms_pkg::pms_stat_s s,
                                                   input logic [`PMS_W-1:0] c,
                                                   input logic [1:0] f);
    logic [`PMS_W-1:0] v;
    v = c;
    case (f)
      `PMS_FLD_MIN: v = s.min;
      `PMS_FLD_AVG: v = stat_avg(s);
      `PMS_FLD_MAX: v = s.max;
      default: v = c;
    endcase
    return v;
  endfunction

  logic is_linked;
  logic want_linked;
  logic clr_all;
  logic clr_cmd;
  logic clr_set0;
  logic clr_set1;
  logic [`PMS_IW-1:0] w_obs;
  logic d_sel;

  assign is_linked = (r_reg.mode == pms_pkg::PMS_MODE_LINKED);
  assign want_linked = cmd_arg[0];
  // commands are taken only between streamed answers
  assign cmd_ready = (r_reg.state == pms_pkg::PMS_IDLE);
  assign w_obs = r_reg.word[`PMS_WC_W-1:2];
  // linked mode points the diagnostic view at the shared set
  assign d_sel = is_linked ? 1'b0 : 1'b1;

  always_comb begin
    r_next = r_reg;
    r_next.rsp_valid = 1'b0;
    r_next.rsp_last = 1'b0;
    r_next.rsp_err = 1'b0;
    clr_all = 1'b0;
    clr_cmd = 1'b0;
    case (r_reg.state)
      pms_pkg::PMS_IDLE: begin
        if (cmd_valid) begin
          r_next.rsp_valid = 1'b1;
          r_next.rsp_last = 1'b1;
          r_next.rsp_data = `PMS_ZERO_WORD;
          case (cmd_code)
            `PMS_CMD_FEAT: begin
              r_next.rsp_data = `PMS_FEAT_GEN;
            end
            `PMS_CMD_PMFEAT: begin
              r_next.rsp_data = `PMS_FEAT_PM;
            end
            `PMS_CMD_MODE: begin
              r_next.mode = want_linked ? pms_pkg::PMS_MODE_LINKED
                                        : pms_pkg::PMS_MODE_INDEP;
              clr_all = (want_linked != is_linked);
            end
            `PMS_CMD_CLEAR: begin
              clr_cmd = 1'b1;
            end
            `PMS_CMD_READ: begin
              r_next.rsp_valid = 1'b0;
              r_next.rsp_last = 1'b0;
              r_next.word = '0;
              r_next.state = pms_pkg::PMS_STREAM;
            end
            default: begin
              r_next.rsp_err = 1'b1;
            end
          endcase
        end
      end
      pms_pkg::PMS_STREAM: begin
        // command path always reads set 0; its streamed words carry no alarm of any kind
        r_next.rsp_valid = 1'b1;
        r_next.rsp_data = stat_field(r_reg.set[0][w_obs], r_reg.cur[w_obs],
                                     r_reg.word[1:0]);
        r_next.word = r_reg.word + {{(`PMS_WC_W-1){1'b0}}, 1'b1};
        if (r_reg.word == `PMS_WC_LAST) begin
          r_next.rsp_last = 1'b1;
          r_next.state = pms_pkg::PMS_IDLE;
        end
      end
      default: begin
        r_next.state = pms_pkg::PMS_IDLE;
      end
    endcase
    if (module_restart) begin
      r_next.mode = pms_pkg::PMS_MODE_INDEP;
      clr_all = 1'b1;
    end
    clr_set0 = clr_all | clr_cmd | (is_linked & diag_clear);
    clr_set1 = clr_all | (~is_linked & diag_clear);
    // clear first, then apply this cycle's sample so it is never lost
    for (int i = 0; i < `PMS_N; i++) begin
      if (clr_set0) begin
        r_next.set[0][i] = stat_clear(r_reg.set[0][i]);
      end
      if (clr_set1) begin
        r_next.set[1][i] = stat_clear(r_reg.set[1][i]);
      end
      if (sample_valid[i]) begin
        r_next.cur[i] = sample_data[i*`PMS_W +: `PMS_W];
        r_next.set[0][i] = stat_update(r_next.set[0][i],
                                       sample_data[i*`PMS_W +: `PMS_W]);
        r_next.set[1][i] = stat_update(r_next.set[1][i],
                                       sample_data[i*`PMS_W +: `PMS_W]);
      end
    end
    r_next.diag_min = r_reg.set[d_sel][diag_obs].min;
    r_next.diag_avg = stat_avg(r_reg.set[d_sel][diag_obs]);
    r_next.diag_max = r_reg.set[d_sel][diag_obs].max;
    r_next.diag_cur = r_reg.cur[diag_obs];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.state <= pms_pkg::PMS_IDLE;
      r_reg.mode <= pms_pkg::PMS_MODE_INDEP;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rsp_valid = r_reg.rsp_valid;
  assign rsp_data = r_reg.rsp_data;
  assign rsp_last = r_reg.rsp_last;
  assign rsp_err = r_reg.rsp_err;
  assign diag_min = r_reg.diag_min;
  assign diag_avg = r_reg.diag_avg;
  assign diag_max = r_reg.diag_max;
  assign diag_cur = r_reg.diag_cur;
  assign linked_mode = is_linked;

endmodule

// [pms_collector_checker.sv]
`timescale 1ns/1ns
`include "pms_consts.svh"
module pms_chk (
  // watched top-level ports
  input wire logic clk,
  input wire logic rst,
  input wire logic [`PMS_N-1:0] sample_valid,
  input wire logic [`PMS_N*`PMS_W-1:0] sample_data,
  input wire logic module_restart,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [15:0] cmd_code,
  input wire logic [15:0] cmd_arg,
  input wire logic rsp_valid,
  input wire logic [`PMS_W-1:0] rsp_data,
  input wire logic rsp_last,
  input wire logic rsp_err,
  input wire logic [`PMS_IW-1:0] diag_obs,
  input wire logic diag_clear,
  input wire logic [`PMS_W-1:0] diag_min,
  input wire logic linked_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic take = cmd_valid && cmd_ready;
  chk_reset_indep: assert property ($fell(rst) |-> !linked_mode && cmd_ready)
    else $error("not independent after reset");
  chk_read_burst: assert property (take && cmd_code == `PMS_CMD_READ |=> !rsp_valid
    ##1 (rsp_valid && !rsp_last && !cmd_ready)[*8] ##1 (rsp_valid && !rsp_last)[*7]
    ##1 (rsp_valid && rsp_last)) else $error("bad read burst");
  chk_short_answer: assert property (take && cmd_code != `PMS_CMD_READ |=> rsp_valid && rsp_last)
    else $error("no single answer");
  chk_feature_word: assert property (take && cmd_code == `PMS_CMD_PMFEAT |=> rsp_data == `PMS_FEAT_PM)
    else $error("bad feature word");
  chk_no_alarm: assert property (take && cmd_code == `PMS_CMD_MODE |=> !rsp_err)
    else $error("error on mode command");
  chk_mode_apply: assert property (take && cmd_code == `PMS_CMD_MODE && !module_restart
    |=> linked_mode == $past(cmd_arg[0])) else $error("mode not applied");
  chk_restart_mode: assert property (module_restart |=> !linked_mode)
    else $error("restart kept linked");
  chk_seed_diag: assert property (diag_clear && !linked_mode && sample_valid[0] && diag_obs == 2'h0
    && !cmd_valid && !module_restart ##1 diag_obs == 2'h0 && !sample_valid[0] && !module_restart
    && !cmd_valid |=> diag_min == $past(sample_data[15:0], 2)) else $error("min not seeded");
endmodule

bind pms_collector pms_chk u_chk (.clk, .rst, .sample_valid, .sample_data, .module_restart,
  .cmd_valid, .cmd_ready, .cmd_code, .cmd_arg, .rsp_valid, .rsp_data, .rsp_last, .rsp_err,
  .diag_obs, .diag_clear, .diag_min, .linked_mode);

// [pms_host.sv]
`timescale 1ns/1ns
module pms_host (
  // request from the bench
  input wire logic clk,
  input wire logic req,
  input wire logic [15:0] req_code,
  input wire logic [15:0] req_arg,
  // command channel
  input wire logic cmd_ready,
  output logic cmd_valid = 1'b0,
  output logic [15:0] cmd_code = 16'h0000,
  output logic [15:0] cmd_arg = 16'h0000
);
  always_ff @(posedge clk) begin
    if (req && !cmd_valid) begin
      cmd_valid <= 1'b1;
      cmd_code <= req_code;
      cmd_arg <= req_arg;
    end else if (cmd_valid && cmd_ready) begin
      // released fields flip so a stale code can never look held
      cmd_valid <= 1'b0;
      cmd_code <= ~cmd_code;
      cmd_arg <= ~cmd_arg;
    end
  end
endmodule

// [test_pms_collector.sv]
`timescale 1ns/1ns
`include "pms_consts.svh"
module test_pms_collector;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] sample_valid = 4'h0;
  logic [63:0] sample_data = 64'h0;
  logic module_restart = 1'b0;
  logic diag_clear = 1'b0;
  logic [1:0] diag_obs = 2'h0;
  logic req = 1'b0;
  logic [15:0] req_code = 16'h0, req_arg = 16'h0, cmd_code, cmd_arg, rsp_data;
  logic [15:0] diag_min, diag_avg, diag_max, diag_cur;
  logic cmd_valid, cmd_ready, rsp_valid, rsp_last, rsp_err, linked_mode;
  logic [15:0] w [16];
  int err_count = 0;
  int n_compared = 0;
  always #4 clk = ~clk;
  pms_host host (.clk, .req, .req_code, .req_arg, .cmd_ready, .cmd_valid, .cmd_code, .cmd_arg);
  pms_collector dut (.clk, .rst, .sample_valid, .sample_data, .module_restart, .cmd_valid,
    .cmd_ready, .cmd_code, .cmd_arg, .rsp_valid, .rsp_data, .rsp_last, .rsp_err, .diag_obs,
    .diag_clear, .diag_min, .diag_avg, .diag_max, .diag_cur, .linked_mode);
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [15:0] code, input logic [15:0] arg);
    int i;
    @(negedge clk);
    req = 1'b1;
    req_code = code;
    req_arg = arg;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      req = 1'b0;
      if (cmd_valid === 1'b1 && cmd_ready === 1'b1) break;
    end
    if (i == 20) begin
      err_count++;
      end_of_test();
    end
    @(negedge clk);
  endtask
  task automatic rd();
    cmd(`PMS_CMD_READ, 16'h0000);
    for (int k = 0; k < 16; k++) begin
      @(negedge clk);
      w[k] = rsp_data;
    end
    check({15'h0000, rsp_last}, 16'h0001);
  endtask
  task automatic samp(input int i, input logic [15:0] d, input logic clr);
    @(negedge clk);
    sample_valid[i] = 1'b1;
    sample_data[16*i +: 16] = d;
    diag_clear = clr;
    @(negedge clk);
    sample_valid = 4'h0;
    diag_clear = 1'b0;
  endtask
  task automatic diag(input logic [1:0] i);
    @(negedge clk);
    diag_obs = i;
    repeat (2) @(negedge clk);
  endtask
  task automatic t_feat();
    cmd(`PMS_CMD_FEAT, 16'h0000);
    check(rsp_data, `PMS_FEAT_GEN);
    check({15'h0000, rsp_err}, 16'h0000);
    cmd(`PMS_CMD_PMFEAT, 16'h0000);
    check(rsp_data, `PMS_FEAT_PM);
    // an undecoded code must be flagged, not silently acknowledged
    cmd(16'h0123, 16'h0000);
    check({15'h0000, rsp_err}, 16'h0001);
  endtask
  task automatic t_stats();
    rd();
    for (int i = 0; i < 4; i++) begin
      samp(i, 16'(i + 16'h000a), 1'b0);
      samp(i, 16'(i + 16'h0014), 1'b0);
    end
    rd();
    for (int i = 0; i < 4; i++) begin
      check(w[4*i], 16'(i + 16'h000a));
      check(w[4*i+1], 16'(i + 16'h000f));
      check(w[4*i+2], 16'(i + 16'h0014));
      check(w[4*i+3], 16'(i + 16'h0014));
    end
  endtask
  task automatic t_modes();
    samp(0, 16'h0007, 1'b1);
    diag(2'h0);
    check(diag_avg, 16'h0007);
    rd();
    // the command set also took the 7, but kept its max and its running sum
    check(w[2], 16'h0014);
    check(w[1], 16'h000c);
    cmd(`PMS_CMD_MODE, 16'h0001);
    check({15'h0000, linked_mode}, 16'h0001);
    rd();
    check(w[2], 16'h0000);
    samp(2, 16'h0009, 1'b0);
    diag(2'h2);
    rd();
    check(diag_max, 16'h0009);
    check(w[10], 16'h0009);
    samp(1, 16'h0003, 1'b1);
    rd();
    check(w[8], 16'h0000);
    check(w[4], 16'h0003);
    @(negedge clk);
    module_restart = 1'b1;
    @(negedge clk);
    module_restart = 1'b0;
    check({15'h0000, linked_mode}, 16'h0000);
  endtask
  task automatic t_clear();
    // independent: a command clear leaves the diagnostic set alone
    samp(3, 16'h0005, 1'b0);
    cmd(`PMS_CMD_CLEAR, 16'h0000);
    check(rsp_data, `PMS_ZERO_WORD);
    diag(2'h3);
    check(diag_max, 16'h0005);
    check(diag_cur, 16'h0005);
    rd();
    check(w[14], 16'h0000);
    check(w[15], 16'h0005);
    // linked: a command clear empties the shared set seen by both paths
    cmd(`PMS_CMD_MODE, 16'h0001);
    samp(0, 16'h0006, 1'b0);
    cmd(`PMS_CMD_CLEAR, 16'h0000);
    diag(2'h0);
    check(diag_max, 16'h0000);
    check(diag_cur, 16'h0006);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check({15'h0000, linked_mode}, 16'h0000);
    t_feat();
    t_stats();
    t_modes();
    t_clear();
    end_of_test();
  end
endmodule
